/* hw/descram_regs_pkg.sv */
// Package: register map, field layout and reset values of the descrambler control bank
`default_nettype none
package descram_regs_pkg;
   // Register addresses (16-bit register index space)
   localparam logic [15:0] ADDR_TX_SCRAM_POLY_LOW = 16'h800F;
   localparam logic [15:0] ADDR_RX_DESCRAM_CONTROL = 16'h8019;
   localparam logic [15:0] ADDR_RX_DESCRAM_SEED_HIGH = 16'h801C;
   localparam logic [15:0] ADDR_RX_DESCRAM_SEED_LOW = 16'h801D;
   localparam logic [15:0] ADDR_RX_DESCRAM_POLY_HIGH = 16'h801E;
   localparam logic [15:0] ADDR_RX_DESCRAM_POLY_LOW = 16'h801F;
   localparam logic [15:0] ADDR_AUTO_SUPERVISION_CONTROL = 16'h8021;
   localparam logic [15:0] ADDR_LOW_SIDE_TX_ERROR_SYMBOL = 16'h8026;
   localparam logic [15:0] ADDR_LOW_SIDE_RX_ERROR_SYMBOL = 16'h8027;
   localparam logic [15:0] ADDR_HIGH_SIDE_RX_ERROR_SYMBOL = 16'h8028;
   localparam logic [15:0] ADDR_STARTUP_PROTOCOL_STATUS = 16'h9020;

   // Reset values
   localparam logic [15:0] RST_TX_SCRAM_POLY_LOW = 16'h00C0;
   localparam logic [15:0] RST_RX_DESCRAM_CONTROL = 16'hFC00;
   localparam logic [15:0] RST_RX_DESCRAM_SEED_HIGH = 16'h0000;
   localparam logic [15:0] RST_RX_DESCRAM_SEED_LOW = 16'h01FC;
   localparam logic [15:0] RST_RX_DESCRAM_POLY_HIGH = 16'h0000;
   localparam logic [15:0] RST_RX_DESCRAM_POLY_LOW = 16'h00C0;
   localparam logic [15:0] RST_AUTO_SUPERVISION_CONTROL = 16'h000A;
   localparam logic [9:0] RST_ERROR_SYMBOL = 10'h2FE;

   // Field positions
   localparam int BIT_NARROW_DESCRAM_EN = 0;
   localparam int BIT_WIDE_DESCRAM_EN = 1;
   localparam int BIT_CLOCK_SQUELCH = 3;
   localparam int BIT_SYNC_CHECK_OFF = 4;
   localparam int BIT_SIGNAL_LOSS_CHECK_OFF = 5;
   localparam int BIT_PLL_LOCK_CHECK_OFF = 6;
   localparam int BIT_STARTUP_IN_PROGRESS = 0;
   localparam int ERROR_SYMBOL_WIDTH = 10;

   // Settings handed to the datapath
   typedef struct packed {
      logic [31:0] tx_scram_polynomial;
      logic rx_wide_descram_enable;
      logic rx_narrow_descram_enable;
      logic [31:0] rx_descram_start_value;
      logic [31:0] rx_descram_polynomial;
   } scram_cfg_t;

   typedef struct packed {
      logic fast_pll_lock_check_off;
      logic fast_signal_loss_check_off;
      logic sync_check_off;
      logic clock_output_auto_squelch;
   } supervision_cfg_t;

   typedef struct packed {
      logic [9:0] low_side_tx_error_symbol;
      logic [9:0] low_side_rx_error_symbol;
      logic [9:0] high_side_rx_error_symbol;
   } error_symbol_cfg_t;
endpackage
`default_nettype wire

/* hw/descrambler_auto_ctrl_regs.sv */
// Control and status register bank for one channel's scrambler, supervision and error symbols
//
// Strobed register access is this design's own decision.
`default_nettype none

module descrambler_auto_ctrl_regs (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [15:0] reg_rdata,
   input wire logic startup_in_progress,
   input wire logic fast_signal_loss,
   input wire logic clock_source_is_recovered,
   output descram_regs_pkg::scram_cfg_t scram_cfg,
   output descram_regs_pkg::supervision_cfg_t supervision_cfg,
   output descram_regs_pkg::error_symbol_cfg_t error_symbol_cfg,
   output logic clock_output_hold
);

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   logic [15:0] tx_poly_low_r;
   logic [15:0] descram_ctrl_r;
   logic [15:0] seed_high_r;
   logic [15:0] seed_low_r;
   logic [15:0] poly_high_r;
   logic [15:0] poly_low_r;
   logic [15:0] auto_ctrl_r;
   logic [9:0] ls_tx_sym_r;
   logic [9:0] ls_rx_sym_r;
   logic [9:0] hs_rx_sym_r;
   logic startup_meta_r;
   logic startup_sync_r;
   logic los_meta_r;
   logic los_sync_r;
   logic src_meta_r;
   logic src_sync_r;
   logic [15:0] rdata_nxt;

   // Upper polynomial word of the transmit scrambler is not stored; this bank drives it as a fixed zero
   localparam logic [15:0] TX_POLY_HIGH_FIXED = 16'h0000;

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   // The carriers must keep the widths the datapath was built for;
   // a package edit that changes them should stop the build here,
   // not surface later as a silent truncation at the datapath
   if ($bits(descram_regs_pkg::scram_cfg_t) != 98) begin : g_scram_width
      $error("scram_cfg_t is not 98 bits wide");
   end
   if ($bits(descram_regs_pkg::error_symbol_cfg_t) !=
       3 * descram_regs_pkg::ERROR_SYMBOL_WIDTH) begin : g_symbol_width
      $error("error_symbol_cfg_t does not hold three symbols");
   end
   if ($bits(descram_regs_pkg::RST_ERROR_SYMBOL) != 10) begin : g_symbol_reset
      $error("error symbol reset value has the wrong width");
   end
   if (descram_regs_pkg::ERROR_SYMBOL_WIDTH > 16) begin : g_symbol_fit
      $error("error symbol wider than a register word");
   end
   if (descram_regs_pkg::BIT_PLL_LOCK_CHECK_OFF > 15) begin : g_field_fit
      $error("supervision field outside a register word");
   end

   // ------------------------------------------------------------
   // Write decode
   // ------------------------------------------------------------
   // One hit per writable word; the address must match exactly, so
   // unmapped holes never disturb stored state. Decoding once here
   // keeps each update process down to its own concern
   logic wr_tx_poly_low;
   logic wr_descram_ctrl;
   logic wr_seed_high;
   logic wr_seed_low;
   logic wr_poly_high;
   logic wr_poly_low;
   logic wr_auto_ctrl;
   logic wr_ls_tx_sym;
   logic wr_ls_rx_sym;
   logic wr_hs_rx_sym;

   // Status word has no hit: writes there are dropped
   assign wr_tx_poly_low = reg_write &&
      (reg_addr == descram_regs_pkg::ADDR_TX_SCRAM_POLY_LOW);
   assign wr_descram_ctrl = reg_write &&
      (reg_addr == descram_regs_pkg::ADDR_RX_DESCRAM_CONTROL);
   assign wr_seed_high = reg_write &&
      (reg_addr == descram_regs_pkg::ADDR_RX_DESCRAM_SEED_HIGH);
   assign wr_seed_low = reg_write &&
      (reg_addr == descram_regs_pkg::ADDR_RX_DESCRAM_SEED_LOW);
   assign wr_poly_high = reg_write &&
      (reg_addr == descram_regs_pkg::ADDR_RX_DESCRAM_POLY_HIGH);
   assign wr_poly_low = reg_write &&
      (reg_addr == descram_regs_pkg::ADDR_RX_DESCRAM_POLY_LOW);
   assign wr_auto_ctrl = reg_write &&
      (reg_addr == descram_regs_pkg::ADDR_AUTO_SUPERVISION_CONTROL);
   assign wr_ls_tx_sym = reg_write &&
      (reg_addr == descram_regs_pkg::ADDR_LOW_SIDE_TX_ERROR_SYMBOL);
   assign wr_ls_rx_sym = reg_write &&
      (reg_addr == descram_regs_pkg::ADDR_LOW_SIDE_RX_ERROR_SYMBOL);
   assign wr_hs_rx_sym = reg_write &&
      (reg_addr == descram_regs_pkg::ADDR_HIGH_SIDE_RX_ERROR_SYMBOL);

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   // Start-up flag arrives from another clock domain; two stages,
   // and only the second stage is ever read
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         startup_meta_r <= 1'b0;
         startup_sync_r <= 1'b0;
      end else begin
         startup_meta_r <= startup_in_progress;
         startup_sync_r <= startup_meta_r;
      end
   end

   // Loss-of-signal flag; a pulse shorter than a cycle may be missed,
   // which costs at most a late squelch
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         los_meta_r <= 1'b0;
         los_sync_r <= 1'b0;
      end else begin
         los_meta_r <= fast_signal_loss;
         los_sync_r <= los_meta_r;
      end
   end

   // Clock source select; changes rarely, two stages are ample
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         src_meta_r <= 1'b0;
         src_sync_r <= 1'b0;
      end else begin
         src_meta_r <= clock_source_is_recovered;
         src_sync_r <= src_meta_r;
      end
   end

   // ------------------------------------------------------------
   // Scrambler setting registers
   // ------------------------------------------------------------
   // Bit 0 of each low word is forced clear so the tap set stays legal
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         tx_poly_low_r <= descram_regs_pkg::RST_TX_SCRAM_POLY_LOW;
      end else if (wr_tx_poly_low) begin
         tx_poly_low_r <= {reg_wdata[15:1], 1'b0};
      end
   end

   // Control word including read-write reserved field
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         descram_ctrl_r <= descram_regs_pkg::RST_RX_DESCRAM_CONTROL;
      end else if (wr_descram_ctrl) begin
         descram_ctrl_r <= reg_wdata;
      end
   end

   // Seed; a zero seed stalls the LFSR, software must avoid it
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         seed_high_r <= descram_regs_pkg::RST_RX_DESCRAM_SEED_HIGH;
         seed_low_r <= descram_regs_pkg::RST_RX_DESCRAM_SEED_LOW;
      end else if (reg_write) begin
         if (wr_seed_high) begin
            seed_high_r <= reg_wdata;
         end
         if (wr_seed_low) begin
            seed_low_r <= {reg_wdata[15:1], 1'b0};
         end
      end
   end

   // Receive polynomial
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         poly_high_r <= descram_regs_pkg::RST_RX_DESCRAM_POLY_HIGH;
         poly_low_r <= descram_regs_pkg::RST_RX_DESCRAM_POLY_LOW;
      end else if (reg_write) begin
         if (wr_poly_high) begin
            poly_high_r <= reg_wdata;
         end
         if (wr_poly_low) begin
            poly_low_r <= {reg_wdata[15:1], 1'b0};
         end
      end
   end

   // ------------------------------------------------------------
   // Supervision control
   // ------------------------------------------------------------
   // Reserved bits are stored as written so read-modify-write is safe
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         auto_ctrl_r <= descram_regs_pkg::RST_AUTO_SUPERVISION_CONTROL;
      end else if (wr_auto_ctrl) begin
         auto_ctrl_r <= reg_wdata;
      end
   end

   // ------------------------------------------------------------
   // Error symbols
   // ------------------------------------------------------------
   // Only ten bits are kept; upper write bits are dropped
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ls_tx_sym_r <= descram_regs_pkg::RST_ERROR_SYMBOL;
         ls_rx_sym_r <= descram_regs_pkg::RST_ERROR_SYMBOL;
         hs_rx_sym_r <= descram_regs_pkg::RST_ERROR_SYMBOL;
      end else if (reg_write) begin
         if (wr_ls_tx_sym) begin
            ls_tx_sym_r <= reg_wdata[9:0];
         end
         if (wr_ls_rx_sym) begin
            ls_rx_sym_r <= reg_wdata[9:0];
         end
         if (wr_hs_rx_sym) begin
            hs_rx_sym_r <= reg_wdata[9:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Datapath outputs
   // ------------------------------------------------------------
   // Scrambler settings; copied one edge late so every output is a
   // flip-flop, at the cost of one cycle of latency after a write
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         scram_cfg <= '0;
      end else begin
         scram_cfg.tx_scram_polynomial <= {TX_POLY_HIGH_FIXED, tx_poly_low_r};
         scram_cfg.rx_wide_descram_enable <=
            descram_ctrl_r[descram_regs_pkg::BIT_WIDE_DESCRAM_EN];
         scram_cfg.rx_narrow_descram_enable <=
            descram_ctrl_r[descram_regs_pkg::BIT_NARROW_DESCRAM_EN];
         scram_cfg.rx_descram_start_value <= {seed_high_r, seed_low_r};
         scram_cfg.rx_descram_polynomial <= {poly_high_r, poly_low_r};
      end
   end

   // Supervision switches; a set bit 4 to 6 turns the automatic check off, a set bit 3 turns clock squelch on
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         supervision_cfg <= '0;
      end else begin
         supervision_cfg.fast_pll_lock_check_off <=
            auto_ctrl_r[descram_regs_pkg::BIT_PLL_LOCK_CHECK_OFF];
         supervision_cfg.fast_signal_loss_check_off <=
            auto_ctrl_r[descram_regs_pkg::BIT_SIGNAL_LOSS_CHECK_OFF];
         supervision_cfg.sync_check_off <=
            auto_ctrl_r[descram_regs_pkg::BIT_SYNC_CHECK_OFF];
         supervision_cfg.clock_output_auto_squelch <=
            auto_ctrl_r[descram_regs_pkg::BIT_CLOCK_SQUELCH];
      end
   end

   // Error symbols; the FIFO logic only uses them when an error strikes,
   // so a write landing mid-frame changes at most one substituted symbol
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         error_symbol_cfg <= '0;
      end else begin
         error_symbol_cfg.low_side_tx_error_symbol <= ls_tx_sym_r;
         error_symbol_cfg.low_side_rx_error_symbol <= ls_rx_sym_r;
         error_symbol_cfg.high_side_rx_error_symbol <= hs_rx_sym_r;
      end
   end

   // ------------------------------------------------------------
   // Clock squelch
   // ------------------------------------------------------------
   // Squelch only applies when the output clock is the recovered one;
   // both status inputs are synchronised, so the hold trails loss by
   // about three edges
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         clock_output_hold <= 1'b0;
      end else begin
         clock_output_hold <= auto_ctrl_r[descram_regs_pkg::BIT_CLOCK_SQUELCH] &&
                              src_sync_r && los_sync_r;
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   // Unmapped addresses read zero; the mux is combinational and only
   // sampled on a read strobe, so idle address changes cost nothing
   // beyond the decode itself
   always_comb begin
      rdata_nxt = 16'h0000;
      case (reg_addr)
         descram_regs_pkg::ADDR_TX_SCRAM_POLY_LOW: begin
            rdata_nxt = tx_poly_low_r;
         end
         descram_regs_pkg::ADDR_RX_DESCRAM_CONTROL: begin
            rdata_nxt = descram_ctrl_r;
         end
         descram_regs_pkg::ADDR_RX_DESCRAM_SEED_HIGH: begin
            rdata_nxt = seed_high_r;
         end
         descram_regs_pkg::ADDR_RX_DESCRAM_SEED_LOW: begin
            rdata_nxt = seed_low_r;
         end
         descram_regs_pkg::ADDR_RX_DESCRAM_POLY_HIGH: begin
            rdata_nxt = poly_high_r;
         end
         descram_regs_pkg::ADDR_RX_DESCRAM_POLY_LOW: begin
            rdata_nxt = poly_low_r;
         end
         descram_regs_pkg::ADDR_AUTO_SUPERVISION_CONTROL: begin
            rdata_nxt = auto_ctrl_r;
         end
         descram_regs_pkg::ADDR_LOW_SIDE_TX_ERROR_SYMBOL: begin
            rdata_nxt = {6'h00, ls_tx_sym_r};
         end
         descram_regs_pkg::ADDR_LOW_SIDE_RX_ERROR_SYMBOL: begin
            rdata_nxt = {6'h00, ls_rx_sym_r};
         end
         descram_regs_pkg::ADDR_HIGH_SIDE_RX_ERROR_SYMBOL: begin
            rdata_nxt = {6'h00, hs_rx_sym_r};
         end
         descram_regs_pkg::ADDR_STARTUP_PROTOCOL_STATUS: begin
            rdata_nxt = {15'h0000, startup_sync_r};
         end
         default: begin
            rdata_nxt = 16'h0000;
         end
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         reg_rdata <= 16'h0000;
      end else if (reg_read) begin
         reg_rdata <= rdata_nxt;
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

endmodule
`default_nettype wire

/* verification/descram_regs_props.sv */
// Port-level assertions for the descrambler control register bank
`default_nettype none
module descram_regs_props (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [15:0] reg_rdata,
   input wire logic startup_in_progress,
   input wire logic fast_signal_loss,
   input wire logic clock_source_is_recovered,
   input wire descram_regs_pkg::scram_cfg_t scram_cfg,
   input wire descram_regs_pkg::supervision_cfg_t supervision_cfg,
   input wire descram_regs_pkg::error_symbol_cfg_t error_symbol_cfg,
   input wire logic clock_output_hold
);
   logic [3:0] settle_r;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);

   // Cycles since reset; synchroniser history is only trusted after a few
   always_ff @(posedge clk_sys) begin
      if (reset) settle_r <= 4'h0;
      else if (settle_r != 4'hF) settle_r <= settle_r + 4'h1;
   end

   // ----------------------------------------
   // Field updates two edges after a write, and output values after reset
   // ----------------------------------------
   a_auto_fields: assert property (reg_write && reg_addr == 16'h8021 |-> ##2
      supervision_cfg == $past(reg_wdata[6:3], 2)) else $error("supervision fields wrong");
   a_enable_bits: assert property (reg_write && reg_addr == 16'h8019 |-> ##2
      {scram_cfg.rx_wide_descram_enable, scram_cfg.rx_narrow_descram_enable}
      == $past(reg_wdata[1:0], 2)) else $error("descrambler enables wrong");
   a_seed_low: assert property (reg_write && reg_addr == 16'h801D |-> ##2
      scram_cfg.rx_descram_start_value[15:0] == {$past(reg_wdata[15:1], 2), 1'b0})
      else $error("seed low word wrong");
   a_poly_low: assert property (reg_write && reg_addr == 16'h801F |-> ##2
      scram_cfg.rx_descram_polynomial[15:0] == {$past(reg_wdata[15:1], 2), 1'b0})
      else $error("rx polynomial low word wrong");
   a_tx_poly: assert property (reg_write && reg_addr == 16'h800F |-> ##2
      scram_cfg.tx_scram_polynomial == {16'h0000, $past(reg_wdata[15:1], 2), 1'b0})
      else $error("tx polynomial wrong");
   a_fast_symbol: assert property (reg_write && reg_addr == 16'h8028 |-> ##2
      error_symbol_cfg.high_side_rx_error_symbol == $past(reg_wdata[9:0], 2))
      else $error("high side error symbol wrong");
   a_reset_values: assert property ($fell(reset) |=>
      scram_cfg == {32'h000000C0, 2'b00, 32'h000001FC, 32'h000000C0}
      && supervision_cfg == 4'b0001 && error_symbol_cfg == {3{10'h2FE}})
      else $error("outputs not at reset values");

   // ----------------------------------------
   // Status read and clock squelch
   // ----------------------------------------
   a_status_read: assert property (settle_r > 4'h4 && reg_read && reg_addr == 16'h9020
      && $stable(startup_in_progress) && $past(startup_in_progress, 2) == startup_in_progress
      && $past(startup_in_progress, 3) == startup_in_progress
      |=> reg_rdata == {15'h0000, $past(startup_in_progress)}) else $error("status bit wrong");
   a_hold_raise: assert property (settle_r > 4'h4 && (fast_signal_loss
      && clock_source_is_recovered && supervision_cfg.clock_output_auto_squelch)[*5]
      |-> clock_output_hold) else $error("clock not held on signal loss");
   a_hold_drop: assert property ((!fast_signal_loss)[*5] |-> !clock_output_hold)
      else $error("clock held without signal loss");
endmodule
bind descrambler_auto_ctrl_regs descram_regs_props props (.clk_sys(clk_sys), .reset(reset),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .startup_in_progress(startup_in_progress),
   .fast_signal_loss(fast_signal_loss), .clock_source_is_recovered(clock_source_is_recovered),
   .scram_cfg(scram_cfg), .supervision_cfg(supervision_cfg),
   .error_symbol_cfg(error_symbol_cfg), .clock_output_hold(clock_output_hold));
`default_nettype wire

/* verification/descrambler_auto_ctrl_regs_test.sv */
// Self-checking bench for the descrambler control register bank
`default_nettype none
module descrambler_auto_ctrl_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic startup_in_progress = 1'b0;
   logic fast_signal_loss = 1'b0;
   logic clock_source_is_recovered = 1'b0;
   logic [15:0] reg_rdata;
   logic clock_output_hold;
   descram_regs_pkg::scram_cfg_t scram_cfg;
   descram_regs_pkg::supervision_cfg_t supervision_cfg;
   descram_regs_pkg::error_symbol_cfg_t error_symbol_cfg;
   int miscompares = 0;
   int checks = 0;
   // Every mapped word plus one unmapped hole, with values straight out of reset
   localparam logic [15:0] addr_tab [12] = '{16'h800F, 16'h8019, 16'h801C, 16'h801D,
      16'h801E, 16'h801F, 16'h8021, 16'h8026, 16'h8027, 16'h8028, 16'h9020, 16'h8020};
   localparam logic [15:0] reset_tab [12] = '{16'h00C0, 16'hFC00, 16'h0000, 16'h01FC,
      16'h0000, 16'h00C0, 16'h000A, 16'h02FE, 16'h02FE, 16'h02FE, 16'h0000, 16'h0000};

   always #5 clk_sys = ~clk_sys;

   descrambler_auto_ctrl_regs DUT (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .startup_in_progress(startup_in_progress), .fast_signal_loss(fast_signal_loss),
      .clock_source_is_recovered(clock_source_is_recovered), .scram_cfg(scram_cfg),
      .supervision_cfg(supervision_cfg), .error_symbol_cfg(error_symbol_cfg),
      .clock_output_hold(clock_output_hold));

   // ----------------------------------------
   // Bus tasks and comparison
   // ----------------------------------------
   task automatic compare(input logic [127:0] got, input logic [127:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h expected=%h", $time, got, exp);
      end
   endtask
   // Strobe is left up; the next task or idle lowers it, so no double drive
   task automatic write_reg(input logic [15:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      reg_read <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic read_reg(input logic [15:0] a, input logic [15:0] exp);
      reg_addr <= a;
      reg_write <= 1'b0;
      reg_read <= 1'b1;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      @(posedge clk_sys);
      compare(reg_rdata, exp);
   endtask
   task automatic idle(input int n);
      reg_write <= 1'b0;
      reg_read <= 1'b0;
      repeat (n) @(posedge clk_sys);
   endtask
   // What a register should hold after writing d
   function automatic logic [15:0] stored(input logic [15:0] a, input logic [15:0] d);
      case (a)
         16'h800F, 16'h801D, 16'h801F: stored = {d[15:1], 1'b0};
         16'h8026, 16'h8027, 16'h8028: stored = {6'h00, d[9:0]};
         16'h9020, 16'h8020: stored = 16'h0000;
         default: stored = d;
      endcase
   endfunction

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic check_resets();
      for (int i = 0; i < 12; i++) begin
         read_reg(addr_tab[i], reset_tab[i]);
      end
   endtask
   // Write then read back at once, then check the settings seen by the datapath
   task automatic sweep(input logic [15:0] d);
      logic [97:0] exp_scram;
      for (int i = 0; i < 12; i++) begin
         write_reg(addr_tab[i], d);
         read_reg(addr_tab[i], stored(addr_tab[i], d));
      end
      idle(2);
      exp_scram = {16'h0000, stored(16'h800F, d), d[1:0], d, stored(16'h801D, d), d,
         stored(16'h801F, d)};
      compare(scram_cfg, exp_scram);
      compare(supervision_cfg, d[6:3]);
      compare(error_symbol_cfg, {3{d[9:0]}});
   endtask
   // Inputs pass a two-stage synchroniser, so allow a few edges to settle
   task automatic hold_case(input logic src, input logic loss, input logic exp);
      clock_source_is_recovered <= src;
      fast_signal_loss <= loss;
      idle(6);
      compare(clock_output_hold, exp);
   endtask

   task automatic summarize();
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Main sequence, including a reset in mid-run
   initial begin
      repeat (8) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      check_resets();
      sweep(16'hFFFF);
      hold_case(1'b1, 1'b1, 1'b1);
      hold_case(1'b1, 1'b0, 1'b0);
      hold_case(1'b0, 1'b1, 1'b0);
      sweep(16'hA5A5);
      hold_case(1'b1, 1'b1, 1'b0);
      startup_in_progress <= 1'b1;
      idle(5);
      read_reg(16'h9020, 16'h0001);
      startup_in_progress <= 1'b0;
      idle(5);
      read_reg(16'h9020, 16'h0000);
      reset <= 1'b1;
      @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      check_resets();
      summarize();
   end

   // Run needs about 175 cycles; this limit leaves wide margin
   initial begin
      #50000;
      miscompares++;
      summarize();
   end
endmodule
`default_nettype wire
